// File: iuc_ctrl.sv
// Overview of operation
// - Single-issue bit restricts issue to lowest queue entries.
// - Bit 16 selects the format of the formatted address read.
// - Wide bit selects 48-bit, else 43-bit address format.
// - Address not equal to its sign extension raises access violation.
// - Wide bit vectors double misses to the four-level entry.
// - Writing transmit bit drives the boot serial clock pin.
// - Kernel enable bit permits privileged reserved opcodes in kernel mode.
// - Upper predict bit forces not-taken, else dynamic prediction.
// - With upper predict bit clear, lower predict bit forces local history, else chooser decides.
// - Prefetch depth field gives stream prefetches after icache miss.
// - Upper shadow bit swaps R4-R7, R20-R23 to shadow registers.
// - Superpage field controls instruction-fetch superpage mapping.
// - Each icache set bit permits fills without invalidating contents.
// - System count bit enables counting on individually enabled counters.
// - Counter increments when enabled and system or process enable set.
`default_nettype none
module iuc_ctrl (
    input wire logic SYS_CLK_I,
    input wire logic SRST_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic HSEL_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HWDATA_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output logic IRQ_O,
    input wire logic SERIAL_DATA_I,
    output logic BOOT_SERIAL_CLOCK_O,
    output logic SINGLE_ISSUE_O,
    output logic HW_KERNEL_EN_O,
    output logic PREDICT_NOT_TAKEN_O,
    output logic PREDICT_LOCAL_ONLY_O,
    output logic [1:0] PREFETCH_DEPTH_O,
    output logic SHADOW_EN_O,
    output logic [2:0] SUPERPAGE_EN_O,
    output logic [1:0] ICACHE_FILL_EN_O,
    output logic DOUBLE_MISS_FOUR_LEVEL_O,
    input wire logic EVENT0_I,
    input wire logic EVENT1_I
);
    import iuc_pkg::*;

    typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_DATA = 2'b01} phase_t;

    logic [CTRL_W-1:0] ctrl_r;
    logic [IRQ_W-1:0] stat_r;
    logic [IRQ_W-1:0] mask_r;
    logic [63:0] check_va_r;
    logic [2:0] perf_r;
    logic [31:0] cnt0_r;
    logic [31:0] cnt1_r;
    logic sync1_r;
    logic sync2_r;
    phase_t phase_r;
    logic wr_pend_r;
    logic [7:0] addr_r;

    // Address phase capture
    wire addr_valid = HSEL_I && HREADY_I &&
        (HTRANS_I == HTRANS_NONSEQ || HTRANS_I == HTRANS_SEQ);
    wire rd_take = addr_valid && !HWRITE_I;
    wire wr_now = wr_pend_r && (phase_r == PH_DATA); // Write lands in its data phase
    wire [7:0] haddr_lo = HADDR_I[7:0];

    // Decode of the data-phase write and the address-phase status read
    wire wr_ctrl = wr_now && (addr_r == CTRL_OFF);
    wire wr_mask = wr_now && (addr_r == IRQ_MASK_OFF);
    wire wr_va_lo = wr_now && (addr_r == CHECK_VA_LO_OFF);
    wire wr_va_hi = wr_now && (addr_r == CHECK_VA_HI_OFF);
    wire wr_perf = wr_now && (addr_r == PERF_CTRL_OFF);
    wire rd_stat = rd_take && (haddr_lo == IRQ_STAT_OFF);

    // Sign-extension checker on the software-loaded address
    logic violation;
    logic [63:0] va_fmt;
    iuc_sext_check u_check (
        .va_i(check_va_r),
        .wide_i(ctrl_r[WIDE_VA_BIT]),
        .form32_i(ctrl_r[FORM32_BIT]),
        .violation_o(violation),
        .formatted_o(va_fmt)
    );

    // Read mux; the write-only transmit bit reads as zero
    wire [31:0] ctrl_rd = {14'h0000, ctrl_r[17:15], sync2_r, 1'b0, ctrl_r[12:0]};
    logic [31:0] rd_mux;
    always_comb begin
        if (haddr_lo == CTRL_OFF) begin
            rd_mux = ctrl_rd;
        end else if (haddr_lo == IRQ_STAT_OFF) begin
            rd_mux = {31'h00000000, stat_r};
        end else if (haddr_lo == IRQ_MASK_OFF) begin
            rd_mux = {31'h00000000, mask_r};
        end else if (haddr_lo == CHECK_VA_LO_OFF) begin
            rd_mux = check_va_r[31:0];
        end else if (haddr_lo == CHECK_VA_HI_OFF) begin
            rd_mux = check_va_r[63:32];
        end else if (haddr_lo == FMT_VA_LO_OFF) begin
            rd_mux = va_fmt[31:0];
        end else if (haddr_lo == FMT_VA_HI_OFF) begin
            rd_mux = va_fmt[63:32];
        end else if (haddr_lo == PERF_CTRL_OFF) begin
            rd_mux = {29'h00000000, perf_r};
        end else if (haddr_lo == COUNT0_OFF) begin
            rd_mux = cnt0_r;
        end else if (haddr_lo == COUNT1_OFF) begin
            rd_mux = cnt1_r;
        end else begin
            rd_mux = 32'h00000000; // Unmapped reads as zero, OKAY
        end
    end

    // Bus phase tracking: slave never inserts wait states
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            phase_r <= PH_IDLE;
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
            HRDATA_O <= 32'h00000000;
        end else begin
            phase_r <= addr_valid ? PH_DATA : PH_IDLE;
            wr_pend_r <= addr_valid && HWRITE_I;
            if (addr_valid) begin
                addr_r <= haddr_lo;
            end
            if (rd_take) begin
                HRDATA_O <= rd_mux;
            end
        end
    end

    // Control register; transmit bit is written like the others
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= {HWDATA_I[17:15], 1'b0, HWDATA_I[13:0]};
        end
    end

    // Software-loaded address, mask and perf enables
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            check_va_r <= 64'h0000000000000000;
            mask_r <= '0;
            perf_r <= 3'h0;
        end else begin
            if (wr_va_lo) check_va_r[31:0] <= HWDATA_I;
            if (wr_va_hi) check_va_r[63:32] <= HWDATA_I;
            if (wr_mask) mask_r <= HWDATA_I[IRQ_W-1:0];
            if (wr_perf) perf_r <= HWDATA_I[2:0];
        end
    end

    // Sticky violation flag: a new event wins over the read-clear
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            stat_r <= '0;
        end else begin
            stat_r[IRQ_VIOL_BIT] <= violation || (stat_r[IRQ_VIOL_BIT] && !rd_stat);
        end
    end

    // Serial data input, two-stage synchroniser for safety
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= SERIAL_DATA_I;
            sync2_r <= sync1_r;
        end
    end

    // Counting permission: individual enable and (system or process)
    wire any_en = ctrl_r[SYS_CNT_BIT] || perf_r[PROC_EN_BIT];
    wire inc0 = EVENT0_I && perf_r[PC0_EN_BIT] && any_en;
    wire inc1 = EVENT1_I && perf_r[PC1_EN_BIT] && any_en;
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            cnt0_r <= 32'h00000000;
            cnt1_r <= 32'h00000000;
        end else begin
            if (inc0) cnt0_r <= cnt0_r + 32'h00000001;
            if (inc1) cnt1_r <= cnt1_r + 32'h00000001;
        end
    end

    // Registered field outputs towards the core; fields already flops
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            IRQ_O <= 1'b0;
            BOOT_SERIAL_CLOCK_O <= 1'b0;
            SINGLE_ISSUE_O <= 1'b0;
            HW_KERNEL_EN_O <= 1'b0;
            PREDICT_NOT_TAKEN_O <= 1'b0;
            PREDICT_LOCAL_ONLY_O <= 1'b0;
            PREFETCH_DEPTH_O <= 2'h0;
            SHADOW_EN_O <= 1'b0;
            SUPERPAGE_EN_O <= 3'h0;
            ICACHE_FILL_EN_O <= 2'h3;
            DOUBLE_MISS_FOUR_LEVEL_O <= 1'b0;
        end else begin
            IRQ_O <= |(stat_r & mask_r);
            if (wr_ctrl) BOOT_SERIAL_CLOCK_O <= HWDATA_I[SERIAL_TX_BIT];
            SINGLE_ISSUE_O <= ctrl_r[SINGLE_ISSUE_BIT];
            HW_KERNEL_EN_O <= ctrl_r[HW_KERNEL_BIT];
            PREDICT_NOT_TAKEN_O <= ctrl_r[BP_HI_BIT];
            // Local-only matters only when the dynamic predictor is in use
            PREDICT_LOCAL_ONLY_O <= !ctrl_r[BP_HI_BIT] && ctrl_r[BP_LO_BIT];
            PREFETCH_DEPTH_O <= ctrl_r[PF_HI:PF_LO];
            SHADOW_EN_O <= ctrl_r[SHADOW_HI_BIT];
            SUPERPAGE_EN_O <= ctrl_r[SP_HI:SP_LO];
            ICACHE_FILL_EN_O <= ctrl_r[IC_HI:IC_LO];
            DOUBLE_MISS_FOUR_LEVEL_O <= ctrl_r[WIDE_VA_BIT];
        end
    end

    assign HREADYOUT_O = 1'b1; // Zero wait states keep the slave simple
    assign HRESP_O = 1'b0;

    // Checks
    property p_reset_icache;
        @(posedge SYS_CLK_I) SRST_I |=> (ctrl_r == CTRL_RESET);
    endproperty
    a_reset_icache: assert property (p_reset_icache) else $error("reset value wrong");

    property p_xmit;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
        wr_ctrl |=> (BOOT_SERIAL_CLOCK_O == $past(HWDATA_I[SERIAL_TX_BIT]));
    endproperty
    a_xmit: assert property (p_xmit) else $error("transmit pin not driven");

    property p_single;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
        wr_ctrl ##1 1 |=> (SINGLE_ISSUE_O == $past(HWDATA_I[SINGLE_ISSUE_BIT], 2));
    endproperty
    a_single: assert property (p_single) else $error("single issue mismatch");

    property p_viol;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
        violation |=> stat_r[IRQ_VIOL_BIT];
    endproperty
    a_viol: assert property (p_viol) else $error("violation not recorded");

    property p_wide;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
        (ctrl_r[WIDE_VA_BIT] && (check_va_r[63:47] == 17'h00000 ||
            check_va_r[63:47] == 17'h1FFFF)) |-> !violation;
    endproperty
    a_wide: assert property (p_wide) else $error("wide format wrong");

    property p_notaken;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
        ctrl_r[BP_HI_BIT] |=> PREDICT_NOT_TAKEN_O && !PREDICT_LOCAL_ONLY_O;
    endproperty
    a_notaken: assert property (p_notaken) else $error("predict mode wrong");

    property p_count;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
        !(perf_r[PC0_EN_BIT] && any_en) |=> $stable(cnt0_r);
    endproperty
    a_count: assert property (p_count) else $error("counter ran while off");

    property p_icache;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
        $changed(ctrl_r[IC_HI:IC_LO]) |=> (ICACHE_FILL_EN_O == $past(ctrl_r[IC_HI:IC_LO]));
    endproperty
    a_icache: assert property (p_icache) else $error("fill enable lag");

    property p_rcv;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
        ##2 1 |-> (sync2_r == $past(SERIAL_DATA_I, 2));
    endproperty
    a_rcv: assert property (p_rcv) else $error("receive sync wrong");

    property p_dmiss;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
        1'b1 |=> (DOUBLE_MISS_FOUR_LEVEL_O == $past(ctrl_r[WIDE_VA_BIT]));
    endproperty
    a_dmiss: assert property (p_dmiss) else $error("double miss select lag");

    property p_local;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
        !ctrl_r[BP_HI_BIT] |=> (PREDICT_LOCAL_ONLY_O == $past(ctrl_r[BP_LO_BIT]));
    endproperty
    a_local: assert property (p_local) else $error("local only select wrong");

    // Interrupt level follows unmasked status one cycle later
    property p_irq;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
        1'b1 |=> (IRQ_O == $past(|(stat_r & mask_r)));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    property p_inc0;
        @(posedge SYS_CLK_I) disable iff (SRST_I)
        inc0 |=> (cnt0_r == $past(cnt0_r) + 32'h00000001);
    endproperty
    a_inc0: assert property (p_inc0) else $error("counter missed an event");
endmodule // iuc_ctrl
`default_nettype wire

// File: iuc_pkg.sv
`default_nettype none
package iuc_pkg;
    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h04;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h08;
    localparam logic [7:0] CHECK_VA_LO_OFF = 8'h0C;
    localparam logic [7:0] CHECK_VA_HI_OFF = 8'h10;
    localparam logic [7:0] FMT_VA_LO_OFF = 8'h14;
    localparam logic [7:0] FMT_VA_HI_OFF = 8'h18;
    localparam logic [7:0] PERF_CTRL_OFF = 8'h1C;
    localparam logic [7:0] COUNT0_OFF = 8'h20;
    localparam logic [7:0] COUNT1_OFF = 8'h24;
    // Control field positions
    localparam int SINGLE_ISSUE_BIT = 17;
    localparam int FORM32_BIT = 16;
    localparam int WIDE_VA_BIT = 15;
    localparam int SERIAL_RX_BIT = 14;
    localparam int SERIAL_TX_BIT = 13;
    localparam int HW_KERNEL_BIT = 12;
    localparam int BP_HI_BIT = 11;
    localparam int BP_LO_BIT = 10;
    localparam int PF_HI = 9;
    localparam int PF_LO = 8;
    localparam int SHADOW_HI_BIT = 7;
    localparam int SP_HI = 5;
    localparam int SP_LO = 3;
    localparam int IC_HI = 2;
    localparam int IC_LO = 1;
    localparam int SYS_CNT_BIT = 0;
    localparam int CTRL_W = 18;
    // Reset value: everything zero except both icache sets enabled
    localparam logic [17:0] CTRL_RESET = 18'h00006;
    // Virtual address widths
    localparam int VA_NARROW = 43;
    localparam int VA_WIDE = 48;
    // Interrupt status bits
    localparam int IRQ_VIOL_BIT = 0;
    localparam int IRQ_W = 1;
    // Perf control bits: counter0 enable, counter1 enable, process enable
    localparam int PC0_EN_BIT = 0;
    localparam int PC1_EN_BIT = 1;
    localparam int PROC_EN_BIT = 2;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage
`default_nettype wire

// File: iuc_sext_check.sv
`default_nettype none
// Combinational sign-extension checker and formatter for one effective address
module iuc_sext_check (
    input wire logic [63:0] va_i,
    input wire logic wide_i,
    input wire logic form32_i,
    output logic violation_o,
    output logic [63:0] formatted_o
);
    import iuc_pkg::*;
    wire [63:0] sext_narrow = {{(64 - VA_NARROW){va_i[VA_NARROW - 1]}}, va_i[VA_NARROW - 1:0]};
    wire [63:0] sext_wide = {{(64 - VA_WIDE){va_i[VA_WIDE - 1]}}, va_i[VA_WIDE - 1:0]};
    wire [63:0] sext_sel = wide_i ? sext_wide : sext_narrow;
    // Violation when the upper bits are not a copy of the sign bit
    assign violation_o = (va_i != sext_sel);
    // 32-bit form keeps the low word sign extended; else the selected width
    assign formatted_o = form32_i ? {{32{va_i[31]}}, va_i[31:0]} : sext_sel;
endmodule // iuc_sext_check
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import iuc_pkg::*;

    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = HSIZE_WORD;
    logic hwrite = 1'b0;
    logic hsel = 1'b0;
    logic serial_in = 1'b0;
    logic ev0 = 1'b0;
    logic ev1 = 1'b0;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, irq, boot_clk, single_issue, hw_kernel;
    wire logic pnt, plo, shadow, dmiss;
    wire logic [1:0] pf, icache;
    wire logic [2:0] sp;
    int num_errors = 0;
    int samples_checked = 0;

    // Single slave: its ready output is the bus ready
    iuc_ctrl iuc_ctrl_i (.SYS_CLK_I(sys_clk), .SRST_I(srst), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HSEL_I(hsel),
        .HREADY_I(hreadyout), .HWDATA_I(hwdata), .HRDATA_O(hrdata),
        .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .IRQ_O(irq),
        .SERIAL_DATA_I(serial_in), .BOOT_SERIAL_CLOCK_O(boot_clk),
        .SINGLE_ISSUE_O(single_issue), .HW_KERNEL_EN_O(hw_kernel),
        .PREDICT_NOT_TAKEN_O(pnt), .PREDICT_LOCAL_ONLY_O(plo), .PREFETCH_DEPTH_O(pf),
        .SHADOW_EN_O(shadow), .SUPERPAGE_EN_O(sp), .ICACHE_FILL_EN_O(icache),
        .DOUBLE_MISS_FOUR_LEVEL_O(dmiss), .EVENT0_I(ev0), .EVENT1_I(ev1));

    // Free-running core clock, 40 ns period
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait for ready; a hung slave ends the run
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                num_errors++;
                conclude();
            end
            @(posedge sys_clk);
        end
    endtask

    // One single word transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv);
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsel <= 1'b1;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdv = hrdata;
        chk("hresp", 32'h0, hresp);
        chk("hready", 32'h1, hreadyout);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask

    // Let field outputs catch up, then look between edges to avoid races
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    // Field outputs and readback derived from a control value
    task automatic fields(input logic [17:0] v);
        logic [17:0] e;
        logic [31:0] x;
        e = v;
        e[SERIAL_TX_BIT] = 1'b0;
        e[SERIAL_RX_BIT] = serial_in;
        settle();
        chk("single_issue", v[SINGLE_ISSUE_BIT], single_issue);
        chk("double_miss", v[WIDE_VA_BIT], dmiss);
        chk("boot_clk", v[SERIAL_TX_BIT], boot_clk);
        chk("hw_kernel", v[HW_KERNEL_BIT], hw_kernel);
        chk("not_taken", v[BP_HI_BIT], pnt);
        chk("local_only", !v[BP_HI_BIT] && v[BP_LO_BIT], plo);
        chk("prefetch", v[PF_HI:PF_LO], pf);
        chk("shadow", v[SHADOW_HI_BIT], shadow);
        chk("superpage", v[SP_HI:SP_LO], sp);
        chk("icache", v[IC_HI:IC_LO], icache);
        @(posedge sys_clk);
        rd(CTRL_OFF, x);
        chk("ctrl", {14'h0, e}, x);
    endtask

    // All fields set with serial input high, then a mixed pattern
    task automatic t_fields;
        serial_in <= 1'b1;
        wr(CTRL_OFF, 32'h0003FFFF);
        fields(18'h3FFFF);
        serial_in <= 1'b0;
        wr(CTRL_OFF, 32'h0001056B);
        fields(18'h1056B);
    endtask

    // Violation in narrow format only, interrupt, masking, formatting
    task automatic t_irq;
        logic [31:0] x;
        wr(IRQ_MASK_OFF, 32'h00000001);
        wr(CTRL_OFF, 32'h00000006);
        wr(CHECK_VA_LO_OFF, 32'h80000000);
        wr(CHECK_VA_HI_OFF, 32'h00000400);
        settle();
        chk("irq", 32'h1, irq);
        @(posedge sys_clk);
        rd(IRQ_STAT_OFF, x);
        chk("stat", 32'h1, x);
        rd(FMT_VA_HI_OFF, x);
        chk("form_hi43", 32'hFFFFFC00, x);
        rd(FMT_VA_LO_OFF, x);
        chk("form_lo43", 32'h80000000, x);
        wr(IRQ_MASK_OFF, 32'h0);
        settle();
        chk("irq_masked", 32'h0, irq);
        @(posedge sys_clk);
        wr(CTRL_OFF, 32'h00008006);
        rd(IRQ_STAT_OFF, x);
        rd(IRQ_STAT_OFF, x);
        chk("stat_wide", 32'h0, x);
        rd(FMT_VA_HI_OFF, x);
        chk("form_hi48", 32'h00000400, x);
        wr(CTRL_OFF, 32'h00018006);
        rd(FMT_VA_HI_OFF, x);
        chk("form_hi32", 32'hFFFFFFFF, x);
        wr(IRQ_MASK_OFF, 32'h00000001);
        settle();
        chk("irq_wide", 32'h0, irq);
        chk("double_miss", 32'h1, dmiss);
        @(posedge sys_clk);
    endtask

    // Ten event cycles under one enable setting
    task automatic t_count(input logic [2:0] pc, input logic sys, input logic [31:0] d0,
                           input logic [31:0] d1);
        logic [31:0] a0, a1, b0, b1;
        wr(CTRL_OFF, {31'h3, sys} | 32'h00008004);
        wr(PERF_CTRL_OFF, {29'h0, pc});
        rd(COUNT0_OFF, a0);
        rd(COUNT1_OFF, a1);
        ev0 <= 1'b1;
        ev1 <= 1'b1;
        repeat (10) @(posedge sys_clk);
        ev0 <= 1'b0;
        ev1 <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(COUNT0_OFF, b0);
        rd(COUNT1_OFF, b1);
        chk("count0", d0, b0 - a0);
        chk("count1", d1, b1 - a1);
    endtask

    // Unmapped place reads zero and ignores writes
    task automatic t_unmapped;
        logic [31:0] x;
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, x);
        chk("unmapped", 32'h0, x);
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        fields(CTRL_RESET);
        t_fields();
        t_irq();
        t_count(3'h1, 1'b1, 32'hA, 32'h0);
        t_count(3'h3, 1'b0, 32'h0, 32'h0);
        t_count(3'h6, 1'b0, 32'h0, 32'hA);
        t_count(3'h3, 1'b1, 32'hA, 32'hA);
        t_unmapped();
        conclude();
    end
endmodule // tb
`default_nettype wire
